// File: verilog/dual_uart_host_ready_dir_ctl.sv
// Function
// - Two active-low selects pick none, channel A, channel B or both.
// - Each channel owns a full independent register set.
// - Per channel 64-byte transmit and receive FIFOs with triggers and levels.
// - Prescaler divides input clock by 1 or 4 under software control.
// - Sampling clock is 8X or 16X the bit rate.
// - Host bus is 8 data, 3 address lines, shared by both channels.
// - Bus cycles are framed only by selects and read/write strobes.
// - Reset high over 40 ns returns registers and serial outputs to default.
// - Divisor zero: high divisor reads identity, low divisor reads revision.
// - Auto direction goes to receive once last stop bit has left.
// - Auto direction returns to transmit when a new byte is loaded.
// - Auto direction is off after reset, enabled by feature bit 3.
// - Direction output high for receive, low for transmit.
// - FIFO control bit 3 selects block mode, cleared means single-character.
// - Single mode: rx ready low while receive FIFO holds a byte.
// - Single mode: tx ready low only while transmit FIFO empty.
// - Block mode: rx ready falls at trigger or timeout, rises when empty.
// - Block mode: tx ready low while transmit FIFO has free room.
// - Line status bit 5 is holding room free, bit 6 transmitter empty.
`timescale 1ns/100ps
`default_nettype none

module byte_fifo
   import duart_host_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH_DEF
)(
   input  wire logic                           core_clk,
   input  wire logic                           rst,
   input  wire logic                           flush,
   input  wire logic                           in_valid,
   output logic                                in_ready,
   input  wire logic [WIDTH-1:0]               in_data,
   output logic                                out_valid,
   input  wire logic                           out_ready,
   output logic [WIDTH-1:0]                    out_data,
   output logic [$clog2(DEPTH+1)-1:0]          level
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [LW-1:0] cnt;
   } fifo_state_t;
   fifo_state_t        s_q;
   fifo_state_t        s_d;
   logic [WIDTH-1:0]   mem [DEPTH];
   logic               push;
   logic               pop;

   // Pointers wrap naturally, so DEPTH must be a power of two
   assign in_ready  = (s_q.cnt != LW'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = mem[s_q.rp];
   assign level     = s_q.cnt;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      s_d = s_q;
      if (flush)
      begin
         s_d = '0;
      end
      else
      begin
         if (push)
            s_d.wp = AW'(s_q.wp + 1'b1);
         if (pop)
            s_d.rp = AW'(s_q.rp + 1'b1);
         s_d.cnt = LW'(s_q.cnt + LW'(push) - LW'(pop));
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   always_ff @(posedge core_clk)
   begin
      if (push && !flush)
         mem[s_q.wp] <= in_data;
   end
endmodule

module dual_uart_host_ready_dir_ctl
   import duart_host_pkg::*;
#(
   parameter int          FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter logic [7:0]  DEVICE_ID  = 8'h5c, // Arbitrary value
   parameter logic [7:0]  REVISION   = 8'h03  // Arbitrary value
)(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              chan_a_select_n,
   input  wire logic              chan_b_select_n,
   input  wire logic              host_read_strobe_n,
   input  wire logic              host_write_strobe_n,
   input  wire logic [2:0]        host_addr,
   input  wire logic [7:0]        host_data_in,
   output logic [7:0]             host_data_out,
   output logic                   host_data_oe,
   input  wire logic [1:0]        rx_byte_valid,
   input  wire logic [1:0][7:0]   rx_byte_data,
   output logic [1:0]             rx_byte_ready,
   input  wire logic [1:0]        rx_timeout,
   output logic [1:0]             tx_serial,
   output logic [1:0]             line_dir,
   output logic [1:0]             rx_ready_n,
   output logic [1:0]             tx_ready_n
);
   localparam int LW = $clog2(FIFO_DEPTH+1);

   typedef struct packed {
      logic [1:0]         csa_s;
      logic [1:0]         csb_s;
      logic [1:0]         rd_s;
      logic [1:0]         wr_s;
      logic [1:0][2:0]    addr_s;
      logic [1:0][7:0]    din_s;
      logic               rd_p;
      logic               wr_p;
      logic [1:0]         w_cs_n;
      logic [2:0]         w_addr;
      logic [7:0]         w_data;
      logic [1:0]         r_cs_n;
      logic [2:0]         r_addr;
      logic [7:0]         dout;
      logic               doe;
      logic [1:0][7:0]    dll;
      logic [1:0][7:0]    divisor_high;
      logic [1:0][7:0]    fifo_ctrl_reg;
      logic [1:0][7:0]    lcr;
      logic [1:0][7:0]    mcr;
      logic [1:0][7:0]    mode;
      logic [1:0][7:0]    feature_ctrl_reg;
      logic [1:0]         rx_blk;
      logic [1:0][1:0]    pre_cnt;
      logic [1:0][15:0]   div_cnt;
      logic [1:0][3:0]    smp_cnt;
      logic [1:0][3:0]    bit_cnt;
      logic [1:0][9:0]    shft;
      logic [1:0]         busy;
   } host_state_t;

   host_state_t            s_q;
   host_state_t            s_d;
   logic [1:0]             tx_push;
   logic [1:0]             tx_pop;
   logic [1:0]             rx_pop;
   logic [1:0]             tx_flush;
   logic [1:0]             rx_flush;
   logic [1:0]             rx_push;
   logic [1:0]             tx_valid;
   logic [1:0]             tx_in_rdy;
   logic [1:0]             rx_valid;
   logic [1:0]             rx_in_rdy;
   logic [1:0][7:0]        tx_data;
   logic [1:0][7:0]        rx_data;
   logic [1:0][LW-1:0]     tx_lvl;
   logic [1:0][LW-1:0]     rx_lvl;

   // Select pins are active low; bit c set means channel c is addressed
   function automatic logic [1:0] chan_hit(input logic [1:0] cs_n);
      chan_hit = ~cs_n;
   endfunction

   assign host_data_out = s_q.dout;
   assign host_data_oe  = s_q.doe;

   always_comb
   begin
      logic        wr_rise;
      logic        rd_rise;
      logic        rc;
      logic        fen;
      logic        pre_tick;
      logic [15:0] div_last;
      logic [3:0]  smp_last;
      logic [7:0]  line_status_reg;
      logic [1:0]  hit;
      wr_rise  = 1'b0;
      hit      = 2'h0;
      rd_rise  = 1'b0;
      rc       = 1'b0;
      fen      = 1'b0;
      pre_tick = 1'b0;
      div_last = '0;
      smp_last = '0;
      line_status_reg      = '0;
      s_d      = s_q;
      tx_push  = '0;
      tx_pop   = '0;
      rx_pop   = '0;
      tx_flush = '0;
      rx_flush = '0;
      rx_push  = '0;
      // Host pins are asynchronous: two stages before use
      s_d.csa_s  = {s_q.csa_s[0], chan_a_select_n};
      s_d.csb_s  = {s_q.csb_s[0], chan_b_select_n};
      s_d.rd_s   = {s_q.rd_s[0], host_read_strobe_n};
      s_d.wr_s   = {s_q.wr_s[0], host_write_strobe_n};
      s_d.addr_s = {s_q.addr_s[0], host_addr};
      s_d.din_s  = {s_q.din_s[0], host_data_in};
      s_d.rd_p   = s_q.rd_s[1];
      s_d.wr_p   = s_q.wr_s[1];
      // Act on strobe release, using what was held while the strobe was low
      wr_rise = s_q.wr_s[1] & ~s_q.wr_p;
      rd_rise = s_q.rd_s[1] & ~s_q.rd_p;
      hit     = chan_hit(s_q.w_cs_n);
      if (!s_q.wr_s[1])
      begin
         s_d.w_cs_n = {s_q.csb_s[1], s_q.csa_s[1]};
         s_d.w_addr = s_q.addr_s[1];
         s_d.w_data = s_q.din_s[1];
      end
      if (!s_q.rd_s[1])
      begin
         s_d.r_cs_n = {s_q.csb_s[1], s_q.csa_s[1]};
         s_d.r_addr = s_q.addr_s[1];
      end
      // A read with both selects low is illegal; stay off the bus then
      s_d.doe = ~s_q.rd_s[1] & (s_q.csa_s[1] ^ s_q.csb_s[1]);
      rc      = s_q.csa_s[1];
      for (int c = 0; c < 2; c++)
      begin
         fen = s_q.fifo_ctrl_reg[c][FIFO_EN_BIT];
         // Without FIFOs each direction holds a single byte
         rx_push[c] = rx_byte_valid[c] & (fen | (rx_lvl[c] == '0));
         // Writes land in every selected channel
         if (wr_rise && hit[c])
         begin
            unique case (s_q.w_addr)
               OFS_DATA:
                  if (s_q.lcr[c][DIV_LATCH_BIT])
                     s_d.dll[c] = s_q.w_data;
                  else
                     tx_push[c] = fen | (tx_lvl[c] == '0);
               OFS_DIV_HIGH:
                  if (s_q.lcr[c][DIV_LATCH_BIT])
                     s_d.divisor_high[c] = s_q.w_data;
               OFS_FIFO_CTRL:
               begin
                  s_d.fifo_ctrl_reg[c]  = s_q.w_data & 8'hf9;
                  rx_flush[c] = s_q.w_data[RX_FLUSH_BIT];
                  tx_flush[c] = s_q.w_data[TX_FLUSH_BIT];
               end
               OFS_LINE_CTRL:
                  s_d.lcr[c] = s_q.w_data;
               OFS_MODEM:
                  s_d.mcr[c] = s_q.w_data;
               OFS_MODE:
                  s_d.mode[c] = s_q.w_data;
               OFS_FEATURE:
                  s_d.feature_ctrl_reg[c] = s_q.w_data;
               default:
                  ;
            endcase
         end
         // Reading the data register consumes a received byte
         rx_pop[c] = rd_rise & (s_q.r_cs_n == ~(2'h1 << c)) & (s_q.r_addr == OFS_DATA)
                     & ~s_q.lcr[c][DIV_LATCH_BIT];
         // Block-mode receive ready latch; clearing on empty wins
         if (rx_lvl[c] == '0)
            s_d.rx_blk[c] = 1'b0;
         else if (rx_timeout[c]
                  || rx_lvl[c] >= LW'(RX_TRIG[s_q.fifo_ctrl_reg[c][TRIG_LSB +: 2]]))
            s_d.rx_blk[c] = 1'b1;
         // Baud timing: prescale, divisor, 8X or 16X sample count
         div_last = ({s_q.divisor_high[c], s_q.dll[c]} == 16'h0000) ? 16'h0000
                    : 16'({s_q.divisor_high[c], s_q.dll[c]} - 16'h0001);
         smp_last = s_q.mode[c][X16_BIT] ? SMP16_LAST : SMP8_LAST;
         pre_tick = ~s_q.mcr[c][PRESCALE_BIT] | (s_q.pre_cnt[c] == PRESC4_LAST);
         if (!s_q.busy[c])
         begin
            s_d.pre_cnt[c] = '0;
            s_d.div_cnt[c] = '0;
            s_d.smp_cnt[c] = '0;
            s_d.bit_cnt[c] = '0;
            if (tx_valid[c])
            begin
               s_d.shft[c] = {1'b1, tx_data[c], 1'b0};
               s_d.busy[c] = 1'b1;
               tx_pop[c]   = 1'b1;
            end
         end
         else
         begin
            s_d.pre_cnt[c] = s_q.mcr[c][PRESCALE_BIT] ? 2'(s_q.pre_cnt[c] + 2'h1) : 2'h0;
            if (pre_tick)
            begin
               if (s_q.div_cnt[c] >= div_last)
               begin
                  s_d.div_cnt[c] = '0;
                  if (s_q.smp_cnt[c] == smp_last)
                  begin
                     s_d.smp_cnt[c] = '0;
                     s_d.shft[c]    = {1'b1, s_q.shft[c][9:1]};
                     if (s_q.bit_cnt[c] == FRAME_LAST)
                        s_d.busy[c] = 1'b0;
                     else
                        s_d.bit_cnt[c] = 4'(s_q.bit_cnt[c] + 4'h1);
                  end
                  else
                     s_d.smp_cnt[c] = 4'(s_q.smp_cnt[c] + 4'h1);
               end
               else
                  s_d.div_cnt[c] = 16'(s_q.div_cnt[c] + 16'h0001);
            end
         end
      end
      // Read data for the one selected channel
      line_status_reg = '0;
      line_status_reg[LSR_RX_BIT]   = (rx_lvl[rc] != '0);
      line_status_reg[LSR_THR_FREE] = s_q.fifo_ctrl_reg[rc][FIFO_EN_BIT] ? tx_in_rdy[rc] : (tx_lvl[rc] == '0);
      line_status_reg[LSR_TX_EMPTY] = (tx_lvl[rc] == '0) & ~s_q.busy[rc];
      unique case (s_q.addr_s[1])
         OFS_DATA:
            if (!s_q.lcr[rc][DIV_LATCH_BIT])
               s_d.dout = rx_data[rc];
            else if ({s_q.divisor_high[rc], s_q.dll[rc]} == 16'h0000)
               s_d.dout = REVISION;
            else
               s_d.dout = s_q.dll[rc];
         OFS_DIV_HIGH:
            if (!s_q.lcr[rc][DIV_LATCH_BIT])
               s_d.dout = 8'h00;
            else if ({s_q.divisor_high[rc], s_q.dll[rc]} == 16'h0000)
               s_d.dout = DEVICE_ID;
            else
               s_d.dout = s_q.divisor_high[rc];
         OFS_FIFO_CTRL:
            s_d.dout = 8'h00;
         OFS_LINE_CTRL:
            s_d.dout = s_q.lcr[rc];
         OFS_MODEM:
            s_d.dout = s_q.mcr[rc];
         OFS_LINE_STAT:
            s_d.dout = line_status_reg;
         OFS_MODE:
            s_d.dout = 8'(rx_lvl[rc]);
         OFS_FEATURE:
            s_d.dout = 8'(tx_lvl[rc]);
         default:
            s_d.dout = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_q        <= '0;
         s_q.csa_s  <= 2'h3;
         s_q.csb_s  <= 2'h3;
         s_q.rd_s   <= 2'h3;
         s_q.wr_s   <= 2'h3;
         s_q.rd_p   <= 1'b1;
         s_q.wr_p   <= 1'b1;
         s_q.w_cs_n <= 2'h3;
         s_q.r_cs_n <= 2'h3;
         s_q.dll    <= {2{DIV_LOW_RST}};
         s_q.divisor_high    <= {2{DIV_HIGH_RST}};
         s_q.fifo_ctrl_reg    <= {2{CTRL_RST}};
         s_q.feature_ctrl_reg   <= {2{CTRL_RST}};
         s_q.mode   <= {2{MODE_RST}};
         s_q.shft   <= {2{SHIFT_IDLE}};
      end
      else
         s_q <= s_d;
   end

   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
         .core_clk  (core_clk),
         .rst       (rst),
         .flush     (tx_flush[c]),
         .in_valid  (tx_push[c]),
         .in_ready  (tx_in_rdy[c]),
         .in_data   (s_q.w_data),
         .out_valid (tx_valid[c]),
         .out_ready (tx_pop[c]),
         .out_data  (tx_data[c]),
         .level     (tx_lvl[c])
      );
      byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
         .core_clk  (core_clk),
         .rst       (rst),
         .flush     (rx_flush[c]),
         .in_valid  (rx_push[c]),
         .in_ready  (rx_in_rdy[c]),
         .in_data   (rx_byte_data[c]),
         .out_valid (rx_valid[c]),
         .out_ready (rx_pop[c]),
         .out_data  (rx_data[c]),
         .level     (rx_lvl[c])
      );
      assign rx_byte_ready[c] = rx_in_rdy[c] & (s_q.fifo_ctrl_reg[c][FIFO_EN_BIT] | ~rx_valid[c]);
      assign tx_serial[c]     = s_q.shft[c][0];
      // Auto mode: receive only once queue and shifter are both drained
      assign line_dir[c] = s_q.feature_ctrl_reg[c][AUTO_DIR_BIT]
                           ? (~s_q.busy[c] & (tx_lvl[c] == '0)) : ~s_q.mcr[c][RTS_BIT];
      assign rx_ready_n[c] = (s_q.fifo_ctrl_reg[c][FIFO_EN_BIT] & s_q.fifo_ctrl_reg[c][BLOCK_BIT])
                             ? ~s_q.rx_blk[c] : (rx_lvl[c] == '0);
      assign tx_ready_n[c] = (s_q.fifo_ctrl_reg[c][FIFO_EN_BIT] & s_q.fifo_ctrl_reg[c][BLOCK_BIT])
                             ? ~tx_in_rdy[c] : (tx_lvl[c] != '0);

      chk_dir_tx_state: assert property (@(posedge core_clk) disable iff (rst)
         s_q.feature_ctrl_reg[c][AUTO_DIR_BIT] && tx_lvl[c] != '0 |-> !line_dir[c])
         else $error("direction not transmit with byte queued");
      chk_dir_rx_idle: assert property (@(posedge core_clk) disable iff (rst)
         s_q.feature_ctrl_reg[c][AUTO_DIR_BIT] && $fell(s_q.busy[c]) && tx_lvl[c] == '0 |-> line_dir[c])
         else $error("direction not receive after last stop bit");
      chk_autodir_reset: assert property (@(posedge core_clk)
         rst |=> !line_dir[c] == s_q.mcr[c][RTS_BIT] && !s_q.feature_ctrl_reg[c][AUTO_DIR_BIT])
         else $error("auto direction active after reset");
      chk_rx_ready_n_single: assert property (@(posedge core_clk) disable iff (rst)
         s_q.fifo_ctrl_reg[c][FIFO_EN_BIT] && !s_q.fifo_ctrl_reg[c][BLOCK_BIT] |-> rx_ready_n[c] == (rx_lvl[c] == '0))
         else $error("single mode rx ready wrong");
      chk_tx_ready_n_single: assert property (@(posedge core_clk) disable iff (rst)
         s_q.fifo_ctrl_reg[c][FIFO_EN_BIT] && !s_q.fifo_ctrl_reg[c][BLOCK_BIT] |-> tx_ready_n[c] == (tx_lvl[c] != '0))
         else $error("single mode tx ready wrong");
      chk_tx_ready_n_block: assert property (@(posedge core_clk) disable iff (rst)
         s_q.fifo_ctrl_reg[c][FIFO_EN_BIT] && s_q.fifo_ctrl_reg[c][BLOCK_BIT]
         |-> tx_ready_n[c] == (tx_lvl[c] == LW'(FIFO_DEPTH)))
         else $error("block mode tx ready wrong");
      chk_rx_ready_n_release: assert property (@(posedge core_clk) disable iff (rst)
         s_q.fifo_ctrl_reg[c][FIFO_EN_BIT] && s_q.fifo_ctrl_reg[c][BLOCK_BIT] && $stable(s_q.fifo_ctrl_reg[c])
         && $past(rx_lvl[c]) == '0 |-> rx_ready_n[c])
         else $error("block mode rx ready not released on empty");
      chk_start_bit: assert property (@(posedge core_clk) disable iff (rst)
         $rose(s_q.busy[c]) |-> !tx_serial[c] ##1 !tx_serial[c])
         else $error("start bit not driven");
      chk_presc_idle: assert property (@(posedge core_clk) disable iff (rst)
         !s_q.mcr[c][PRESCALE_BIT] && s_q.busy[c] |=> s_q.pre_cnt[c] == 2'h0)
         else $error("prescaler counting while divide by 1");
   end
endmodule
`default_nettype wire

// File: verilog/duart_host_pkg.sv
`default_nettype none
package duart_host_pkg;
   // Register offsets within one channel
   localparam logic [2:0] OFS_DATA      = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH  = 3'h1;
   localparam logic [2:0] OFS_FIFO_CTRL = 3'h2;
   localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
   localparam logic [2:0] OFS_MODEM     = 3'h4;
   localparam logic [2:0] OFS_LINE_STAT = 3'h5;
   localparam logic [2:0] OFS_MODE      = 3'h6;
   localparam logic [2:0] OFS_FEATURE   = 3'h7;
   // Reset values
   localparam logic [7:0] DIV_LOW_RST   = 8'h01;
   localparam logic [7:0] DIV_HIGH_RST  = 8'h00;
   localparam logic [7:0] CTRL_RST      = 8'h00;
   localparam logic [7:0] MODE_RST      = 8'h80;
   localparam logic [9:0] SHIFT_IDLE    = 10'h3ff;
   // Field positions
   localparam int FIFO_EN_BIT    = 0;
   localparam int RX_FLUSH_BIT   = 1;
   localparam int TX_FLUSH_BIT   = 2;
   localparam int BLOCK_BIT      = 3;
   localparam int TRIG_LSB       = 6;
   localparam int DIV_LATCH_BIT  = 7;
   localparam int RTS_BIT        = 1;
   localparam int PRESCALE_BIT   = 7;
   localparam int X16_BIT        = 7;
   localparam int AUTO_DIR_BIT   = 3;
   localparam int LSR_RX_BIT     = 0;
   localparam int LSR_THR_FREE   = 5;
   localparam int LSR_TX_EMPTY   = 6;
   // Counts
   localparam logic [1:0] PRESC4_LAST  = 2'h3;
   localparam logic [3:0] SMP16_LAST   = 4'hf;
   localparam logic [3:0] SMP8_LAST    = 4'h7;
   localparam logic [3:0] FRAME_LAST   = 4'h9;
   localparam int FIFO_DEPTH_DEF       = 64;
   // Receive trigger levels selected by fifo_ctrl_reg[7:6]
   localparam logic [3:0][6:0] RX_TRIG = {7'h38, 7'h20, 7'h10, 7'h01};
endpackage
`default_nettype wire

// File: testbench/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   input  wire logic       core_clk,
   output logic            chan_a_select_n,
   output logic            chan_b_select_n,
   output logic            host_read_strobe_n,
   output logic            host_write_strobe_n,
   output logic [2:0]      host_addr,
   output logic [7:0]      host_data_in,
   input  wire logic [7:0] host_data_out,
   input  wire logic       host_data_oe,
   output logic            rd_done,
   output logic [8:0]      rd_val
);
   initial
   begin
      {chan_a_select_n, chan_b_select_n} = 2'h3;
      {host_read_strobe_n, host_write_strobe_n} = 2'h3;
      host_addr    = 3'h0;
      host_data_in = 8'h00;
      rd_done      = 1'b0;
      rd_val       = 9'h000;
   end
   // One access; selects, address and data stand until the strobe is long gone
   task automatic access(input logic [1:0] cs, input logic wr, input logic [2:0] a,
                         input logic [7:0] d);
      @(posedge core_clk);
      {chan_b_select_n, chan_a_select_n} <= ~cs;
      host_addr <= a;
      host_data_in <= d;
      host_write_strobe_n <= ~wr;
      host_read_strobe_n <= wr | (cs == 2'h3);
      repeat (5) @(posedge core_clk);
      rd_val <= {host_data_oe, host_data_out};
      rd_done <= ~wr;
      {host_read_strobe_n, host_write_strobe_n} <= 2'h3;
      @(posedge core_clk);
      rd_done <= 1'b0;
      repeat (2) @(posedge core_clk);
      {chan_b_select_n, chan_a_select_n} <= 2'h3;
      // Released bus must not look like the last value
      host_data_in <= ~d;
      repeat (2) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// File: testbench/dual_uart_host_ready_dir_ctl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dual_uart_host_ready_dir_ctl_tb import duart_host_pkg::*;;
   localparam logic [7:0] ID  = 8'h3e; // Arbitrary identity value
   localparam logic [7:0] REV = 8'h07; // Arbitrary revision value
   logic             core_clk = 1'b0;
   logic             rst = 1'b1;
   logic             cs_a_n, cs_b_n, rd_n, wr_n, oe, rd_done;
   logic [2:0]       addr;
   logic [7:0]       din, dout;
   logic [8:0]       rd_val;
   logic [1:0]       rx_valid = 2'h0, rx_rdy, rx_to = 2'h0, txs, dir, rxr_n, txr_n;
   logic [1:0][7:0]  rx_data = '0;
   logic [15:0]      exp_q[$];
   logic [15:0]      note;
   logic [7:0]       rxq[$];
   int               errors = 0, num_checks = 0, cnt;
   always #5 core_clk = ~core_clk;
   host_bus_model host_bus_model_i (.core_clk(core_clk), .chan_a_select_n(cs_a_n),
      .chan_b_select_n(cs_b_n), .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
      .host_addr(addr), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
      .rd_done(rd_done), .rd_val(rd_val));
   dual_uart_host_ready_dir_ctl #(.FIFO_DEPTH(32), .DEVICE_ID(ID), .REVISION(REV))
      dual_uart_host_ready_dir_ctl_i (.core_clk(core_clk), .rst(rst),
      .chan_a_select_n(cs_a_n), .chan_b_select_n(cs_b_n), .host_read_strobe_n(rd_n),
      .host_write_strobe_n(wr_n), .host_addr(addr), .host_data_in(din),
      .host_data_out(dout), .host_data_oe(oe), .rx_byte_valid(rx_valid),
      .rx_byte_data(rx_data), .rx_byte_ready(rx_rdy), .rx_timeout(rx_to),
      .tx_serial(txs), .line_dir(dir), .rx_ready_n(rxr_n), .tx_ready_n(txr_n));
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] d);
      host_bus_model_i.access(cs, 1'b1, a, d);
   endtask
   task automatic rd(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] e,
                     input logic [7:0] m);
      exp_q.push_back({m, e & m});
      host_bus_model_i.access(cs, 1'b0, a, 8'h00);
   endtask
   // Offered bytes are held until the accepting edge
   task automatic fill(input int ch, input int n);
      rx_valid[ch] <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         rx_data[ch] <= 8'($urandom);
         cnt = 0;
         do
         begin
            @(posedge core_clk);
            cnt++;
         end while (rx_rdy[ch] !== 1'b1 && cnt < 50);
         check(cnt < 50, 1'b1);
         rxq.push_back(rx_data[ch]);
      end
      rx_valid[ch] <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   // Channel A frame; serial line sampled mid-bit, bt cycles per bit
   task automatic send(input logic [7:0] d, input int bt);
      logic [9:0] sh;
      sh = '0;
      wr(2'h1, OFS_DATA, d);
      check(dir, 2'h2);
      cnt = 0;
      while (dir[0] !== 1'b1 && cnt < 800)
      begin
         @(posedge core_clk);
         cnt++;
         if (cnt % bt == bt / 2)
            sh = {txs[0], sh[9:1]};
      end
      check(cnt >= 10 * bt - 2 && cnt <= 10 * bt + 3, 1'b1);
      check(sh[9:1], {1'b1, d});
      check(sh[0], 1'b0);
   endtask
   always @(posedge core_clk)
      if (rd_done === 1'b1)
      begin
         note = exp_q.pop_front();
         check(rd_val & {1'b1, note[15:8]}, {1'b1, note[7:0]});
      end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      results();
   end
   initial
   begin
      void'($urandom(32'h4ec447f7));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check({oe, rxr_n, txr_n, dir, txs}, 9'h0cf);
      wr(2'h3, OFS_LINE_CTRL, 8'h80);
      wr(2'h1, OFS_DATA, 8'h00);
      wr(2'h1, OFS_DIV_HIGH, 8'h00);
      wr(2'h2, OFS_DIV_HIGH, 8'h10);
      rd(2'h1, OFS_DIV_HIGH, ID, 8'hff);
      rd(2'h1, OFS_DATA, REV, 8'hff);
      rd(2'h2, OFS_DIV_HIGH, 8'h10, 8'hff);
      rd(2'h2, OFS_DATA, 8'h01, 8'hff);
      wr(2'h3, OFS_LINE_CTRL, 8'h03);
      fill(0, 1);
      check(rxr_n, 2'h2);
      rd(2'h1, OFS_DATA, rxq.pop_front(), 8'hff);
      check(rxr_n, 2'h3);
      wr(2'h1, OFS_FEATURE, 8'h08);
      check({dir, txr_n}, 4'hc);
      // Divisor zero counts as one: 16 cycles a bit
      send(8'h5a, 16);
      rd(2'h1, OFS_LINE_STAT, 8'h60, 8'h60);
      // Prescale by 4 with 8X sampling: 32 cycles a bit
      wr(2'h1, OFS_MODEM, 8'h80);
      wr(2'h1, OFS_MODE, 8'h00);
      send(8'($urandom), 32);
      wr(2'h2, OFS_FIFO_CTRL, 8'h01);
      check(txr_n[1], 1'b0);
      wr(2'h2, OFS_DATA, 8'h11);
      wr(2'h2, OFS_DATA, 8'h22);
      check(txr_n[1], 1'b1);
      wr(2'h2, OFS_FIFO_CTRL, 8'h49);
      check(txr_n[1], 1'b0);
      for (int i = 0; i < 31; i++)
         wr(2'h2, OFS_DATA, 8'($urandom));
      check(txr_n[1], 1'b1);
      rd(2'h2, OFS_LINE_STAT, 8'h00, 8'h60);
      fill(1, 1);
      check(rxr_n[1], 1'b1);
      rx_to[1] <= 1'b1;
      @(posedge core_clk);
      rx_to[1] <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(rxr_n[1], 1'b0);
      rd(2'h2, OFS_DATA, rxq.pop_front(), 8'hff);
      check(rxr_n[1], 1'b1);
      fill(1, 15);
      check(rxr_n[1], 1'b1);
      fill(1, 1);
      check(rxr_n[1], 1'b0);
      fill(1, 16);
      check(rx_rdy[1], 1'b0);
      while (rxq.size() > 0)
         rd(2'h2, OFS_DATA, rxq.pop_front(), 8'hff);
      check(rxr_n, 2'h3);
      results();
   end
endmodule
`default_nettype wire
